// ==== dv/hdcc_checker.sv ====
// Assertion checker for the clamp configuration bank, bound to hdcc_regs.
// Assumes host and calibration writes to 0x23 never share a cycle.
`timescale 1ns/100ps
module hdcc_checker import hdcc_pkg::*; (
  input wire logic        mclk, srst, reg_wr, reg_rd, calib_gain_wr,
  input wire logic        resonant_mode, calib_active, diag_active,
  input wire logic        overdrive_done, below_battery_threshold_one,
  input wire logic        below_battery_threshold_two,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, drive_clamp,
  input wire logic [7:0]  base_overdrive_clamp,
  input wire logic [1:0]  calib_gain, loop_gain, backemf_amp_gain,
  input wire logic [11:0] backemf_gain_x100
);
  logic [7:0] s23, s24, s25, s26, rd_e, act, ex_n, ex_q;
  logic [1:0] q;
  logic       cal;
  assign cal = calib_active | diag_active;
  assign act = cal ? base_overdrive_clamp : below_battery_threshold_two ? s26
             : below_battery_threshold_one ? s25 : base_overdrive_clamp;
  assign ex_n = (overdrive_done && s24 < act) ? s24 : act;
  assign rd_e = reg_addr == 8'h23 ? s23 : reg_addr == 8'h24 ? s24
              : reg_addr == 8'h25 ? s25 : reg_addr == 8'h26 ? s26 : 8'h00;
  always_ff @(posedge mclk) begin
    if (srst) s23 <= 8'h36;
    else if (reg_wr && reg_addr == 8'h23) s23 <= reg_wdata;
    else if (calib_gain_wr) s23[1:0] <= calib_gain;
  end
  always_ff @(posedge mclk) begin
    if (srst) {s24, s25, s26} <= 24'h648000;
    else if (reg_wr && reg_addr == 8'h24) s24 <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h25) s25 <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h26) s26 <= reg_wdata;
  end
  // The clamp path lags its inputs, so only quiet stretches are judged.
  always_ff @(posedge mclk) begin
    ex_q <= ex_n;
    if (srst || reg_wr || calib_gain_wr || !$stable({cal, overdrive_done,
        base_overdrive_clamp, below_battery_threshold_one,
        below_battery_threshold_two})) q <= 2'h0;
    else if (q != 2'h3) q <= q + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_calib_base: assert property (
    q == 2'h3 && $past(cal) && !$past(overdrive_done) |->
    drive_clamp == $past(base_overdrive_clamp)) else $error("calib clamp");
  a_lvl_two: assert property (
    q == 2'h3 && !$past(cal) && $past(below_battery_threshold_two) &&
    !$past(overdrive_done) |-> drive_clamp == s26) else $error("lvl2 clamp");
  a_lvl_one: assert property (
    q == 2'h3 && !$past(cal || below_battery_threshold_two || overdrive_done)
    && $past(below_battery_threshold_one) |-> drive_clamp == s25)
    else $error("lvl1 clamp");
  a_steady_cap: assert property (
    q == 2'h3 && $past(overdrive_done) |-> drive_clamp <= s24)
    else $error("steady cap");
  a_clamp_min: assert property (
    q == 2'h3 |-> drive_clamp == ex_q) else $error("clamp select");
  a_read_data: assert property (
    reg_rd && !reg_wr |-> ##2 reg_rdata == $past(rd_e, 2))
    else $error("read data");
  a_gain_follow: assert property (
    $changed(s23[3:0]) |-> ##[1:2] {loop_gain, backemf_amp_gain} == s23[3:0])
    else $error("gain fields");
  a_gain_decode: assert property (
    ($stable(backemf_amp_gain) && $stable(resonant_mode))[*3]
    ##0 !$past(srst) |->
    backemf_gain_x100 == (resonant_mode ? HDCC_LRA_GAIN_X100[backemf_amp_gain]
    : HDCC_ERM_GAIN_X100[backemf_amp_gain])) else $error("gain decode");
endmodule
bind hdcc_regs hdcc_checker u_hdcc_checker (.*);

// ==== dv/hdcc_host.sv ====
// Host model that drives the byte register port of hdcc_regs.
// Assumes strobes are sampled on the rising edge of mclk.
`timescale 1ns/100ps
module hdcc_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr, reg_wdata,
  output logic reg_wr, reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // An idle bus shows inverted values so that stale data cannot match.
    reg_addr <= ~a;
    reg_wdata <= ~dv;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dv);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    #1 dv = reg_rdata;
  endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the clamp configuration bank.
// Assumes the host model owns the register port of the design.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  logic mclk = 0, srst = 1, calib_gain_wr = 0, resonant_mode = 1;
  logic calib_active = 0, diag_active = 0, overdrive_done = 0;
  logic below_battery_threshold_one = 0, below_battery_threshold_two = 0;
  logic [1:0] calib_gain = 2'h0, loop_gain, backemf_amp_gain;
  logic [7:0] base_overdrive_clamp = 8'hC8, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] drive_clamp, d;
  logic reg_wr, reg_rd;
  logic [11:0] backemf_gain_x100;
  int bad_count = 0, n_checks = 0, cyc = 0, i;
  logic [11:0] gx [8] = '{12'h022, 12'h069, 12'h0B6, 12'h190,
                          12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8};
  logic [12:0] ct [8] = '{13'h00C8, 13'h0470, 13'h0630, 13'h16C8,
                          13'h0CC8, 13'h0150, 13'h0730, 13'h0550};
  hdcc_regs u_hdcc_regs (.*);
  hdcc_host u_hdcc_host (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_hdcc_host.rd(a, d);
    `CHK("reg", e, d)
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rdchk(8'h23, 8'h36);
    rdchk(8'h24, 8'h64);
    rdchk(8'h25, 8'h80);
    rdchk(8'h26, 8'h00);
    $display("test reset_values done");
    u_hdcc_host.wr(8'h24, 8'h50);
    u_hdcc_host.wr(8'h25, 8'h70);
    u_hdcc_host.wr(8'h26, 8'h30);
    u_hdcc_host.wr(8'h27, 8'hAA);
    rdchk(8'h27, 8'h00);
    rdchk(8'h25, 8'h70);
    $display("test write_read done");
    for (i = 0; i < 8; i++) begin
      u_hdcc_host.wr(8'h23, {6'h3F, i[1:0]});
      resonant_mode <= i[2];
      repeat (4) @(posedge mclk);
      #1 `CHK("gain_x100", gx[i], backemf_gain_x100)
      `CHK("loop_gain", 2'h3, loop_gain)
    end
    $display("test gain_decode done");
    @(posedge mclk);
    calib_gain_wr <= 1'b1;
    calib_gain    <= 2'h1;
    @(posedge mclk);
    calib_gain_wr <= 1'b0;
    rdchk(8'h23, 8'hFD);
    `CHK("cal_gain", 2'h1, backemf_amp_gain)
    u_hdcc_host.wr(8'h23, 8'h06);
    rdchk(8'h23, 8'h06);
    $display("test calibration done");
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      {calib_active, diag_active, below_battery_threshold_one,
       below_battery_threshold_two, overdrive_done} <= ct[i][12:8];
      repeat (4) @(posedge mclk);
      #1 `CHK("clamp", ct[i][7:0], drive_clamp)
    end
    $display("test clamp_select done");
    print_verdict();
  end
endmodule

// ==== logic/hdcc_clamp_if.sv ====
// Interface carrying clamp levels and battery state to the selector.
// Assumes one clock domain; the interface holds no logic.
`timescale 1ns/100ps
interface hdcc_clamp_if;
  logic [7:0] base_overdrive_clamp;
  logic [7:0] steady_voltage_clamp;
  logic [7:0] overdrive_clamp_low_batt_one;
  logic [7:0] overdrive_clamp_low_batt_two;
  logic       below_battery_threshold_one;
  logic       below_battery_threshold_two;
  logic       calib_or_diag;
  logic       overdrive_done;
  logic [7:0] active_overdrive_clamp;
  logic [7:0] drive_clamp;
  modport src (
    output base_overdrive_clamp, steady_voltage_clamp,
    output overdrive_clamp_low_batt_one, overdrive_clamp_low_batt_two,
    output below_battery_threshold_one, below_battery_threshold_two,
    output calib_or_diag, overdrive_done,
    input  active_overdrive_clamp, drive_clamp
  );
  modport sel (
    input  base_overdrive_clamp, steady_voltage_clamp,
    input  overdrive_clamp_low_batt_one, overdrive_clamp_low_batt_two,
    input  below_battery_threshold_one, below_battery_threshold_two,
    input  calib_or_diag, overdrive_done,
    output active_overdrive_clamp, drive_clamp
  );
endinterface

// ==== logic/hdcc_clamp_sel.sv ====
// Combinational clamp selector for the drive level.
// Assumes its inputs are registered in the caller.
`timescale 1ns/100ps
module hdcc_clamp_sel (
  // Clamp levels and selection state
  hdcc_clamp_if.sel cif
);
  import hdcc_pkg::*;

  function automatic logic [7:0] hdcc_min(input logic [7:0] a,
                                          input logic [7:0] b);
    hdcc_min = (a < b) ? a : b;
  endfunction

  always_comb begin
    // Level two overrides level one; both are ignored in calibration.
    if (cif.calib_or_diag) begin
      cif.active_overdrive_clamp = cif.base_overdrive_clamp; // (R10)
    end else if (cif.below_battery_threshold_two) begin
      cif.active_overdrive_clamp = cif.overdrive_clamp_low_batt_two; // (R9)
    end else if (cif.below_battery_threshold_one) begin
      cif.active_overdrive_clamp = cif.overdrive_clamp_low_batt_one; // (R8)
    end else begin
      cif.active_overdrive_clamp = cif.base_overdrive_clamp;
    end
    // (R11)
    if (cif.overdrive_done) begin
      // (R5) (R6) (R7)
      cif.drive_clamp = hdcc_min(cif.steady_voltage_clamp,
                                 cif.active_overdrive_clamp);
    end else begin
      cif.drive_clamp = cif.active_overdrive_clamp;
    end
  end
endmodule

// ==== logic/hdcc_pkg.sv ====
// Package for the haptic drive clamp configuration block.
// Assumes a byte-wide register port addressed by an eight-bit index.
package hdcc_pkg;
  localparam logic [7:0] HDCC_OFS_GAIN       = 8'h23;
  localparam logic [7:0] HDCC_OFS_STEADY     = 8'h24;
  localparam logic [7:0] HDCC_OFS_OD_LVL1    = 8'h25;
  localparam logic [7:0] HDCC_OFS_OD_LVL2    = 8'h26;
  localparam int         HDCC_LOOP_GAIN_LSB  = 2;
  localparam int         HDCC_BACKEMF_AMP_GAIN_LSB  = 0;
  localparam logic [1:0] HDCC_LOOP_GAIN_RST  = 2'h1;
  localparam logic [1:0] HDCC_BACKEMF_AMP_GAIN_RST  = 2'h2;
  localparam logic [7:0] HDCC_GAIN_UPPER_RST = 8'h30;
  localparam logic [7:0] HDCC_STEADY_RST     = 8'h64;
  localparam logic [7:0] HDCC_OD_LVL1_RST    = 8'h80;
  localparam logic [7:0] HDCC_OD_LVL2_RST    = 8'h00;
  // Back-EMF gain in hundredths: resonant 5,10,20,30; eccentric .34..4.
  localparam logic [11:0] HDCC_LRA_GAIN_X100 [4] =
    '{12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8};
  localparam logic [11:0] HDCC_ERM_GAIN_X100 [4] =
    '{12'h022, 12'h069, 12'h0B6, 12'h190};
endpackage

// ==== logic/hdcc_regs.sv ====
// Register bank and clamp selection for the haptic drive configuration.
// Assumes the serial control port delivers decoded byte reads and
// single-cycle write strobes synchronous to mclk.
`timescale 1ns/100ps

// Functional notes
// (R1) Loop gain field at bits 3:2 sets feedback settling speed.
// (R2) Back-EMF amplifier gain at bits 1:0, resets to 2, mode dependent.
// (R3) Gain codes map to 5/10/20/30x resonant, .34/1.05/1.82/4x eccentric.
// (R4) Calibration writes gain field; later host writes replace it.
// (R5) Steady clamp, reset 100, applies after the overdrive section.
// (R6) Lower active overdrive clamp replaces steady clamp.
// (R7) Triggered battery level clamp likewise applies if lower.
// (R8) Level one clamp, reset 128, replaces base below threshold one.
// (R9) Level two clamp, reset 0, replaces both below threshold two.
// (R10) Calibration and diagnostics use only the base overdrive clamp; after overdrive_done the steady clamp still caps it if lower.
// (R11) Clamp chosen every cycle from comparators and registers.
module hdcc_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Calibration engine
  input  wire logic        calib_gain_wr,
  input  wire logic [1:0]  calib_gain,
  // Operating state
  input  wire logic        resonant_mode,
  input  wire logic        calib_active,
  input  wire logic        diag_active,
  input  wire logic        overdrive_done,
  input  wire logic [7:0]  base_overdrive_clamp,
  input  wire logic        below_battery_threshold_one,
  input  wire logic        below_battery_threshold_two,
  // Outputs to the drive path
  output logic      [1:0]  loop_gain,
  output logic      [1:0]  backemf_amp_gain,
  output logic      [11:0] backemf_gain_x100,
  output logic      [7:0]  drive_clamp
);
  import hdcc_pkg::*;

  logic [7:0] gain_upper_reg;
  logic [1:0] loop_gain_reg;
  logic [1:0] backemf_amp_gain_reg;
  logic [7:0] steady_reg;
  logic [7:0] od_lvl1_reg;
  logic [7:0] od_lvl2_reg;
  logic [7:0] base_od_reg;
  logic       bt1_reg;
  logic       bt2_reg;
  logic       cal_diag_reg;
  logic       od_done_reg;
  logic [7:0] rdata_next;

  hdcc_clamp_if cif ();

  function automatic logic [11:0] hdcc_gain_x100(input logic       lra,
                                                 input logic [1:0] code);
    hdcc_gain_x100 = lra ? HDCC_LRA_GAIN_X100[code]
                         : HDCC_ERM_GAIN_X100[code];
  endfunction

  // Gain register: upper bits are kept for the noise gate and brake fields.
  always_ff @(posedge mclk) begin
    if (srst) begin
      gain_upper_reg <= HDCC_GAIN_UPPER_RST;
      loop_gain_reg  <= HDCC_LOOP_GAIN_RST;
      backemf_amp_gain_reg  <= HDCC_BACKEMF_AMP_GAIN_RST; // (R2)
    end else if (reg_wr && reg_addr == HDCC_OFS_GAIN) begin
      // A host write in the same cycle wins, being the later intent.
      gain_upper_reg <= {reg_wdata[7:4], 4'h0};
      loop_gain_reg  <= reg_wdata[HDCC_LOOP_GAIN_LSB +: 2]; // (R1)
      backemf_amp_gain_reg  <= reg_wdata[HDCC_BACKEMF_AMP_GAIN_LSB +: 2]; // (R4)
    end else if (calib_gain_wr) begin
      backemf_amp_gain_reg  <= calib_gain; // (R4)
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      steady_reg  <= HDCC_STEADY_RST; // (R5)
      od_lvl1_reg <= HDCC_OD_LVL1_RST; // (R8)
      od_lvl2_reg <= HDCC_OD_LVL2_RST; // (R9)
    end else if (reg_wr) begin
      case (reg_addr)
        HDCC_OFS_STEADY:  steady_reg  <= reg_wdata;
        HDCC_OFS_OD_LVL1: od_lvl1_reg <= reg_wdata;
        HDCC_OFS_OD_LVL2: od_lvl2_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Operating inputs are sampled so the selector sees stable values.
  always_ff @(posedge mclk) begin
    if (srst) begin
      base_od_reg  <= 8'h00;
      bt1_reg      <= 1'b0;
      bt2_reg      <= 1'b0;
      cal_diag_reg <= 1'b0;
      od_done_reg  <= 1'b0;
    end else begin
      base_od_reg  <= base_overdrive_clamp;
      bt1_reg      <= below_battery_threshold_one; // (R11)
      bt2_reg      <= below_battery_threshold_two; // (R11)
      cal_diag_reg <= calib_active | diag_active; // (R10)
      od_done_reg  <= overdrive_done;
    end
  end

  assign cif.base_overdrive_clamp         = base_od_reg;
  assign cif.steady_voltage_clamp         = steady_reg;
  assign cif.overdrive_clamp_low_batt_one = od_lvl1_reg;
  assign cif.overdrive_clamp_low_batt_two = od_lvl2_reg;
  assign cif.below_battery_threshold_one  = bt1_reg;
  assign cif.below_battery_threshold_two  = bt2_reg;
  assign cif.calib_or_diag                = cal_diag_reg;
  assign cif.overdrive_done               = od_done_reg;

  hdcc_clamp_sel u_sel (
    .cif (cif.sel)
  );

  always_comb begin
    case (reg_addr)
      HDCC_OFS_GAIN:    rdata_next = {gain_upper_reg[7:4], loop_gain_reg,
                                      backemf_amp_gain_reg};
      HDCC_OFS_STEADY:  rdata_next = steady_reg;
      HDCC_OFS_OD_LVL1: rdata_next = od_lvl1_reg;
      HDCC_OFS_OD_LVL2: rdata_next = od_lvl2_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  // Outputs are registered, so they lag the register state by one cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata         <= 8'h00;
      loop_gain         <= HDCC_LOOP_GAIN_RST;
      backemf_amp_gain  <= HDCC_BACKEMF_AMP_GAIN_RST;
      backemf_gain_x100 <= 12'h000;
      drive_clamp       <= 8'h00;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
      loop_gain         <= loop_gain_reg; // (R1)
      backemf_amp_gain  <= backemf_amp_gain_reg; // (R2)
      backemf_gain_x100 <= hdcc_gain_x100(resonant_mode,
                                          backemf_amp_gain_reg); // (R3)
      drive_clamp       <= cif.drive_clamp; // (R11)
    end
  end
endmodule
